// >>> multi_function_timer.sv
// Output pin stage of a three-channel timer: modes, pin levels, port hand-over.
// Assumes software drives the plain control ports in the documented order.
//
// How it works
// R1 - Reset: timer outputs low, pins undriven
// R2 - Pin starts at initial level, match changes it
// R3 - PWM1 leaves B and D pins undriven
// R4 - PWM2 cycle register pin gets no waveform
// R5 - PWM2 cycle register is the A register
// R6 - Software uses port output for undriven pins
// R7 - Software sets mode, levels, routing, then starts
// R8 - On error, software forces port non-active output
// R9 - Then software clears the count start bit
// R10 - With counting stopped, set mode unless unchanged
// R11 - Then rewrite I/O control to set levels
// R12 - Then route pins back to the timer
// R13 - Finally set count start bit again
// R14 - Active level low, non-active level high
// R15 - Phase counting only on channels 1 and 2
module multi_function_timer #(
   parameter int NUM_CH = timer_pin_pkg::NUM_CHANNELS,
   parameter int CNT_W = timer_pin_pkg::CNT_WIDTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Mode and counting control
   input wire timer_pin_pkg::op_mode_type mode_i [NUM_CH],
   input wire logic [NUM_CH-1:0] count_start_bit_i,
   input wire logic [CNT_W-1:0] period_i [NUM_CH],
   input wire logic [CNT_W-1:0] compare_i [NUM_CH][timer_pin_pkg::PINS_PER_CH],
   // Pin level control
   input wire logic [NUM_CH-1:0] io_init_stb_i,
   input wire timer_pin_pkg::io_ctrl_type timer_io_control_setting_i
      [NUM_CH][timer_pin_pkg::PINS_PER_CH],
   // Port and pin function control
   input wire timer_pin_pkg::port_ctrl_type port_ctrl_i [NUM_CH][timer_pin_pkg::PINS_PER_CH],
   // Pins and status
   output timer_pin_pkg::pin_drive_type pin_o [NUM_CH][timer_pin_pkg::PINS_PER_CH],
   output logic [timer_pin_pkg::PINS_PER_CH-1:0] timer_level_o [NUM_CH],
   output timer_pin_pkg::op_mode_type mode_o [NUM_CH],
   output logic [NUM_CH-1:0] running_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Phase counting allowed only from channel 1 up
   function automatic logic mode_legal(input int ch, input timer_pin_pkg::op_mode_type m);
      mode_legal = (m != timer_pin_pkg::MODE_PHASE) || (ch >= timer_pin_pkg::PHASE_FIRST_CH);
   endfunction

   // Whether a pin may carry a waveform in a mode
   function automatic logic wave_ok(input timer_pin_pkg::op_mode_type m, input int pin);
      case (m)
         timer_pin_pkg::MODE_PWM1: begin
            wave_ok = (pin != timer_pin_pkg::PIN_B) && (pin != timer_pin_pkg::PIN_D); // [R3]
         end
         timer_pin_pkg::MODE_PWM2: begin
            wave_ok = (pin != timer_pin_pkg::PIN_A); // [R4] [R5]
         end
         default: begin
            wave_ok = 1'b1;
         end
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode latch and counters

   timer_pin_pkg::op_mode_type mode_q [NUM_CH];
   timer_pin_pkg::op_mode_type mode_d [NUM_CH];
   logic [CNT_W-1:0] cnt_q [NUM_CH];
   logic [CNT_W-1:0] cnt_d [NUM_CH];
   logic [timer_pin_pkg::PINS_PER_CH-1:0] match [NUM_CH];

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         mode_d[c] = mode_q[c];
         cnt_d[c] = cnt_q[c];
         // Mode is taken only while stopped
         if (!count_start_bit_i[c] && mode_legal(c, mode_i[c])) begin
            mode_d[c] = mode_i[c]; // [R10] [R15]
         end
         if (count_start_bit_i[c]) begin
            if (cnt_q[c] >= period_i[c]) begin
               cnt_d[c] = CNT_W'(timer_pin_pkg::CNT_RESET);
            end else begin
               cnt_d[c] = cnt_q[c] + CNT_W'(timer_pin_pkg::CNT_ONE);
            end
         end
         for (int p = 0; p < timer_pin_pkg::PINS_PER_CH; p++) begin
            match[c][p] = count_start_bit_i[c] && (cnt_q[c] == compare_i[c][p]);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_q[c] <= timer_pin_pkg::MODE_NORMAL;
            cnt_q[c] <= CNT_W'(timer_pin_pkg::CNT_RESET);
         end
      end else begin
         mode_q <= mode_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      for (genvar p = 0; p < timer_pin_pkg::PINS_PER_CH; p++) begin : g_pin
         timer_pin_cell u_cell (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .init_stb_i(io_init_stb_i[c]), // [R2]
            .match_i(match[c][p]),
            .wave_allowed_i(wave_ok(mode_q[c], p)),
            .io_ctrl_i(timer_io_control_setting_i[c][p]),
            .port_ctrl_i(port_ctrl_i[c][p]),
            .pin_o(pin_o[c][p]),
            .level_o(timer_level_o[c][p])
         );
      end
      assign mode_o[c] = mode_q[c];
      assign running_o[c] = count_start_bit_i[c];
   end

endmodule

// >>> timer_pin_pkg.sv
// Shared constants and carrier types for the timer output pin block.
// Assumes one clock domain and plain-port configuration from software.
package timer_pin_pkg;

   localparam int NUM_CHANNELS = 3;
   localparam int PINS_PER_CH = 4;
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_C = 2;
   localparam int PIN_D = 3;
   localparam int CNT_WIDTH = 16;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic RESET_LEVEL = 1'b0;
   localparam logic NONACTIVE_LEVEL = 1'b1;
   localparam int PHASE_FIRST_CH = 1;

   // Operating mode encoding
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_PWM1 = 2'h1,
      MODE_PWM2 = 2'h2,
      MODE_PHASE = 2'h3
   } op_mode_type;

   // One I/O control setting for one pin
   typedef struct packed {
      logic enable;
      logic initial_level;
      logic match_level;
   } io_ctrl_type;

   // Port logic setting for one pin
   typedef struct packed {
      logic port_mode_timer;
      logic port_direction_out;
      logic port_output_data;
   } port_ctrl_type;

   // Pin drive bundle
   typedef struct packed {
      logic out;
      logic oe_b;
   } pin_drive_type;

endpackage

// >>> timer_pin_cell.sv
// One timer output pin: timer level latch plus port multiplexer.
// Assumes compare match pulses and control levels synchronous to clk_i.
module timer_pin_cell (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Timer side
   input wire logic init_stb_i,
   input wire logic match_i,
   input wire logic wave_allowed_i,
   input wire timer_pin_pkg::io_ctrl_type io_ctrl_i,
   // Port side
   input wire timer_pin_pkg::port_ctrl_type port_ctrl_i,
   // Pin
   output timer_pin_pkg::pin_drive_type pin_o,
   output logic level_o
);

   logic level_q;
   logic level_d;
   timer_pin_pkg::pin_drive_type pin_q;
   timer_pin_pkg::pin_drive_type pin_d;

   always_comb begin
      level_d = level_q;
      if (init_stb_i && wave_allowed_i && io_ctrl_i.enable) begin
         level_d = io_ctrl_i.initial_level; // [R2] [R3] [R4]
      end else if (match_i && wave_allowed_i && io_ctrl_i.enable) begin
         level_d = io_ctrl_i.match_level; // [R2]
      end
   end

   always_comb begin
      pin_d.out = timer_pin_pkg::RESET_LEVEL;
      pin_d.oe_b = 1'b1;
      if (port_ctrl_i.port_mode_timer) begin
         if (wave_allowed_i && io_ctrl_i.enable) begin
            pin_d.out = level_q;
            pin_d.oe_b = 1'b0;
         end // [R3] [R4] undriven otherwise
      end else if (port_ctrl_i.port_direction_out) begin
         pin_d.out = port_ctrl_i.port_output_data; // [R6] [R8] [R14]
         pin_d.oe_b = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_q <= timer_pin_pkg::RESET_LEVEL; // [R1]
         pin_q.out <= timer_pin_pkg::RESET_LEVEL;
         pin_q.oe_b <= 1'b1; // [R1]
      end else begin
         level_q <= level_d;
         pin_q <= pin_d;
      end
   end

   assign pin_o = pin_q;
   assign level_o = level_q;

endmodule

// >>> pin_load.sv
// Loads on the timer pins: a pull-up on every pin line.
// Assumes the pin bundle of multi_function_timer.
module pin_load (
   // Pins
   input wire timer_pin_pkg::pin_drive_type pin_i [3][4],
   // Line levels
   output logic [11:0] wire_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         wire_o[i] = pin_i[i / 4][i % 4].oe_b ? 1'b1 : pin_i[i / 4][i % 4].out;
      end
   end
endmodule

// >>> multi_function_timer_props.sv
// Checker for the timer output pin stage.
// Assumes it is bound to multi_function_timer.
module timer_props #(parameter int NUM_CH = 3) (
   // Inputs
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire timer_pin_pkg::op_mode_type mode_i [NUM_CH],
   input wire logic [NUM_CH-1:0] count_start_bit_i,
   input wire logic [NUM_CH-1:0] io_init_stb_i,
   input wire timer_pin_pkg::io_ctrl_type timer_io_control_setting_i [NUM_CH][4],
   input wire timer_pin_pkg::port_ctrl_type port_ctrl_i [NUM_CH][4],
   // Outputs
   input wire timer_pin_pkg::pin_drive_type pin_o [NUM_CH][4],
   input wire logic [3:0] timer_level_o [NUM_CH],
   input wire timer_pin_pkg::op_mode_type mode_o [NUM_CH]
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   //////////
   a_reset_state: assert property (rst_b_i && !$past(rst_b_i) |->
      timer_level_o[0] == 4'h0 && pin_o[0][0] == 2'h1) else $error("reset state");
   a_init_level: assert property (io_init_stb_i[0] && timer_io_control_setting_i[0][2].enable
      |=> timer_level_o[0][2] == $past(timer_io_control_setting_i[0][2].initial_level))
      else $error("init level");
   a_pwm1_undriven: assert property ((mode_o[0] == 2'h1 && port_ctrl_i[0][1].port_mode_timer
      && port_ctrl_i[0][3].port_mode_timer) ##1 mode_o[0] == 2'h1
      |-> pin_o[0][1].oe_b && pin_o[0][3].oe_b) else $error("pwm1 pin driven");
   a_pwm1_frozen: assert property (mode_o[0] == 2'h1 ##1 mode_o[0] == 2'h1 |->
      $stable(timer_level_o[0][1]) && $stable(timer_level_o[0][3])) else $error("pwm1 level");
   a_pwm2_undriven: assert property ((mode_o[0] == 2'h2 && port_ctrl_i[0][0].port_mode_timer)
      ##1 mode_o[0] == 2'h2 |-> pin_o[0][0].oe_b) else $error("pwm2 pin driven");
   a_pwm2_frozen: assert property (mode_o[0] == 2'h2 ##1 mode_o[0] == 2'h2 |->
      $stable(timer_level_o[0][0])) else $error("pwm2 level");
   a_port_level: assert property (!port_ctrl_i[0][0].port_mode_timer
      && port_ctrl_i[0][0].port_direction_out
      |=> pin_o[0][0] == {$past(port_ctrl_i[0][0].port_output_data), 1'b0}) else $error("port");
   a_no_phase_ch0: assert property (mode_o[0] != 2'h3) else $error("phase on ch0");
   a_phase_ch1: assert property (!count_start_bit_i[1] && mode_i[1] == 2'h3 |=>
      mode_o[1] == 2'h3) else $error("phase on ch1");
   a_mode_hold: assert property (count_start_bit_i[0] |=> $stable(mode_o[0]))
      else $error("mode changed");
   c_phase: cover property (mode_o[1] == 2'h3);
   c_pwm2: cover property (mode_o[0] == 2'h2 && pin_o[0][0].oe_b);
   c_match: cover property ($rose(timer_level_o[0][2]));
endmodule
bind multi_function_timer timer_props #(.NUM_CH(NUM_CH)) props_u (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .mode_i(mode_i), .count_start_bit_i(count_start_bit_i),
   .io_init_stb_i(io_init_stb_i), .timer_io_control_setting_i(timer_io_control_setting_i),
   .port_ctrl_i(port_ctrl_i), .pin_o(pin_o), .timer_level_o(timer_level_o), .mode_o(mode_o));

// >>> tb_multi_function_timer.sv
// Bench for the timer pin stage: error shutdown and recovery in normal, PWM1 and PWM2 modes.
// Assumes pin_load as the pulled-up loads on the pins.
module tb_multi_function_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_b_i;
   logic [2:0] run, stb, running;
   timer_pin_pkg::op_mode_type mode [3], mode_o [3];
   logic [15:0] per [3], cmp [3][4];
   timer_pin_pkg::io_ctrl_type ioc [3][4];
   timer_pin_pkg::port_ctrl_type prt [3][4];
   timer_pin_pkg::pin_drive_type pin [3][4];
   logic [3:0] lvl [3];
   logic [11:0] wire_lvl;
   int errors, cmp_count, seed, n;
   multi_function_timer dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode),
      .count_start_bit_i(run), .period_i(per), .compare_i(cmp), .io_init_stb_i(stb),
      .timer_io_control_setting_i(ioc), .port_ctrl_i(prt), .pin_o(pin),
      .timer_level_o(lvl), .mode_o(mode_o), .running_o(running));
   pin_load load_u (.pin_i(pin), .wire_o(wire_lvl));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   //////////
   task automatic end_sim();
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic undriven(input int m, input int p);
      return (m == 1 && p % 2 == 1) || (m == 2 && p == 0);
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic ports(input logic tmr);
      @(posedge clk_i);
      for (int p = 0; p < 4; p++) prt[0][p] <= '{tmr, 1'b1, 1'b1};
   endtask
   //////////
   initial begin
      seed = 32'h25a7;
      errors = 0;
      cmp_count = 0;
      rst_b_i = 1'b0;
      run = 3'h0;
      stb = 3'h0;
      for (int c = 0; c < 3; c++) begin
         mode[c] = timer_pin_pkg::MODE_NORMAL;
         per[c] = 16'h0010;
         for (int p = 0; p < 4; p++) begin
            cmp[c][p] = 16'h0000;
            ioc[c][p] = '{1'b1, 1'b0, 1'b1};
            prt[c][p] = '{1'b0, 1'b0, 1'b0};
         end
      end
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      for (int p = 0; p < 4; p++) chk({lvl[0][p], pin[0][p].oe_b}, 2'h1);
      for (int k = 0; k < 3; k++) begin
         ports(1'b0);
         tick(2);
         for (int p = 0; p < 4; p++) chk(pin[0][p], 2'h2);
         @(posedge clk_i);
         run[0] <= 1'b0;
         mode[0] <= timer_pin_pkg::op_mode_type'(k);
         repeat (2) @(posedge clk_i);
         stb[0] <= 1'b1;
         cmp[0][2] <= (k == 0) ? per[0] : 16'h0001 + 16'($unsigned($random(seed)) % 15);
         @(posedge clk_i);
         stb[0] <= 1'b0;
         chk(mode_o[0], 2'(k));
         ports(1'b1);
         tick(2);
         for (int p = 0; p < 4; p++) chk({1'b0, wire_lvl[p]}, {1'b0, undriven(k, p)});
         @(posedge clk_i);
         run[0] <= 1'b1;
         tick(1);
         chk({1'b0, running[0]}, 2'h1);
         n = 0;
         while (pin[0][2].out !== 1'b1 && n < 40) begin
            tick(1);
            n++;
         end
         if (n == 40) begin
            errors++;
            end_sim();
         end
         chk(pin[0][2], 2'h2);
         chk({lvl[0][2], 1'b0}, 2'h2);
      end
      @(posedge clk_i);
      run <= 3'h0;
      mode[0] <= timer_pin_pkg::MODE_PHASE;
      mode[1] <= timer_pin_pkg::MODE_PHASE;
      tick(2);
      chk(mode_o[0], 2'h2);
      chk(mode_o[1], 2'h3);
      end_sim();
   end
endmodule
